// ===== pkg/rcei_pkg.sv
package rcei_pkg;
	// Register byte addresses
	localparam logic [7:0] ADDR_RX_COMMAND = 8'h00;
	localparam logic [7:0] ADDR_CMD_STATUS = 8'h04;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
	localparam logic [7:0] ADDR_EVENT_STATUS = 8'h0c;
	// Event bit positions in the low 24 bits
	localparam int EV_RX_DONE = 0;
	localparam int EV_RX_OTHER = 1;
	localparam int EV_TX = 8;
	localparam int EV_FIFO = 16;
	localparam int EV_TIMER = 20;
	// Master enable sits in the top bit of the mask register
	localparam int MASK_MASTER_BIT = 31;
	// Command status fields
	localparam int CS_DONE_LSB = 24;
	localparam int CS_FREE_LSB = 0;
	// Receive command fields
	localparam int CMD_LEN_LSB = 0;
	localparam int CMD_ID_LSB = 16;
	// Command queue depth
	localparam int QUEUE_DEPTH = 8;
	localparam logic [3:0] QUEUE_DEPTH_V = 4'h8;
	// Reset values
	localparam logic [31:0] MASK_RESET = 32'h0000_0000;
	localparam logic [23:0] EVENT_RESET = 24'h00_0000;
	localparam logic [7:0] DONE_RESET = 8'h00;
	// Receive header alignment in bytes
	localparam logic [15:0] HDR_ALIGN_MASK = 16'h0007;
	localparam logic [15:0] HDR_SIZE = 16'h0008;
endpackage

// ===== design/rcei_cmd_mem.sv
`timescale 1ns/100ps
`default_nettype none
// Small memory holding queued receive commands; registered read data
module rcei_cmd_mem
	import rcei_pkg::*;
(
	// Clock
	input wire logic pclk,
	// Write port
	input wire logic wr_en,
	input wire logic [2:0] wr_addr,
	input wire logic [31:0] wr_data,
	// Read port
	input wire logic [2:0] rd_addr,
	output logic [31:0] rd_data
);
	logic [31:0] mem [QUEUE_DEPTH];

	// Store and fetch
	always_ff @(posedge pclk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule
`default_nettype wire

// ===== design/rcei_top.sv
// Notes on behaviour
// - Four event categories: receive, transmit, FIFO, timer
// - Event bits stay set until read
// - Read returns contents, then clears register
// - Clear touches only byte lanes read
// - Top byte mirrors completed command count
// - Reading top byte zeroes done count; code subtracts the value the read returned
// - Read while interrupt high drops master enable
// - No interrupt while master enable is zero (irq is registered, so it falls one cycle after a write clears master enable)
// - Per-event mask bit gates interrupt
// - Masks never stop event bits setting
// - Gated result drives interrupt output
// - Free count shows commands still acceptable
// - Finished commands set done event bit
// - Headers start on 8-byte aligned positions
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module rcei_top
	import rcei_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Event sources, one-cycle pulses
	input wire logic rx_event,
	input wire logic tx_event,
	input wire logic fifo_event,
	input wire logic timer_event,
	// Receive engine side: finishes the oldest queued command
	input wire logic rx_cmd_finish,
	input wire logic [15:0] rx_pkt_len,
	output logic [31:0] rx_cur_cmd,
	output logic rx_cur_valid,
	output logic [15:0] rx_next_hdr_offset,
	// Interrupt toward host
	output logic irq
);
	// Bus decode
	wire access = psel && penable;
	wire wr = access && pwrite;
	wire rd = access && !pwrite;
	wire hit_cmd = paddr == ADDR_RX_COMMAND;
	wire hit_cs = paddr == ADDR_CMD_STATUS;
	wire hit_mask = paddr == ADDR_IRQ_MASK;
	wire hit_ev = paddr == ADDR_EVENT_STATUS;
	wire mapped = hit_cmd | hit_cs | hit_mask | hit_ev;

	// State
	logic [23:0] event_bits; // Sticky low 24 bits of event status
	logic [7:0] rx_cmd_done_count; // Completed command count
	logic [31:0] mask; // Mask bits plus master enable
	logic [3:0] fill; // Commands waiting
	logic [2:0] wptr;
	logic [2:0] rptr;
	logic [31:0] mem_q;
	logic [15:0] hdr_off;

	wire irq_master_enable = mask[MASK_MASTER_BIT];
	wire [3:0] rx_cmd_free_count = QUEUE_DEPTH_V - fill;
	wire queue_full = fill == QUEUE_DEPTH_V;
	wire queue_empty = fill == 4'h0;
	wire push = wr && hit_cmd && !queue_full;
	wire pop = rx_cmd_finish && !queue_empty;

	// Read lanes of the event register that are cleared
	wire ev_rd = rd && hit_ev;
	wire [3:0] lane_clr = ev_rd ? pstrb : 4'h0;
	wire [23:0] clr_mask;
	wire [23:0] set_bits;

	// Per-byte clear mask over the three sticky bytes
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_lane
			assign clr_mask[gi*8 +: 8] = {8{lane_clr[gi]}};
		end
	endgenerate

	// Event sources; status is set regardless of masks
	assign set_bits = (24'h1 << EV_RX_DONE) & {24{pop}}
		| (24'h1 << EV_RX_OTHER) & {24{rx_event}}
		| (24'h1 << EV_TX) & {24{tx_event}}
		| (24'h1 << EV_FIFO) & {24{fifo_event}}
		| (24'h1 << EV_TIMER) & {24{timer_event}};

	// Full event view, top byte aliases done count
	wire [31:0] event_view = {rx_cmd_done_count, event_bits};
	wire [31:0] pending = event_view & mask;
	wire next_irq = irq_master_enable && (pending[30:0] != 31'h0);

	// Sticky events: set wins over clear. Only bits that the read returned
	// are cleared: an event landing on the setup edge missed the captured
	// read data and must survive the access edge.
	wire [23:0] read_clr = clr_mask & prdata[23:0]; // Returned and accessed bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			event_bits <= EVENT_RESET;
		end else begin
			event_bits <= (event_bits & ~read_clr) | set_bits;
		end
	end

	// Completed count. A read of the top byte subtracts what it returned, so
	// a finish that lands between setup and access is kept for the next read.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_cmd_done_count <= DONE_RESET;
		end else if (lane_clr[3]) begin
			rx_cmd_done_count <= rx_cmd_done_count - prdata[31:24] + {7'h00, pop};
		end else if (pop) begin
			rx_cmd_done_count <= rx_cmd_done_count + 8'h01;
		end
	end

	// Mask register; read while irq high drops master enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask <= MASK_RESET;
		end else if (wr && hit_mask) begin
			mask <= pwdata;
		end else if (ev_rd && irq) begin
			mask[MASK_MASTER_BIT] <= 1'b0;
		end
	end

	// Interrupt line, registered so the pin never glitches; a clearing
	// read with irq high forces it low on the next cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= next_irq && !(ev_rd && irq);
		end
	end

	// Fill level after this edge, and the head address the memory reads
	wire [3:0] next_fill = fill + {3'h0, push} - {3'h0, pop};
	wire [2:0] rd_sel = pop ? rptr + 3'h1 : rptr; // Step past a popped head
	// A write into the slot being read returns stale data for one cycle
	wire rd_collide = push && (wptr == rd_sel);

	// Command queue pointers, in order
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wptr <= 3'h0;
			rptr <= 3'h0;
			fill <= 4'h0;
		end else begin
			if (push) begin
				wptr <= wptr + 3'h1;
			end
			if (pop) begin
				rptr <= rptr + 3'h1;
			end
			fill <= next_fill;
		end
	end

	rcei_cmd_mem u_mem (
		.pclk(pclk),
		.wr_en(push),
		.wr_addr(wptr),
		.wr_data(pwdata),
		.rd_addr(rd_sel),
		.rd_data(mem_q)
	);

	// Head-of-queue valid; it waits a cycle whenever the registered memory
	// read the slot being written, since that word came out stale
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_cur_valid <= 1'b0;
		end else begin
			rx_cur_valid <= next_fill != 4'h0 && !rd_collide;
		end
	end
	assign rx_cur_cmd = mem_q;

	// Next receive header offset, rounded to 8 bytes
	// Restarts at zero whenever the head command is finished
	wire [15:0] hdr_end = hdr_off + HDR_SIZE + rx_pkt_len + HDR_ALIGN_MASK;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hdr_off <= 16'h0000;
		end else if (pop) begin
			hdr_off <= 16'h0000;
		end else if (rx_event) begin
			hdr_off <= hdr_end & ~HDR_ALIGN_MASK;
		end
	end
	assign rx_next_hdr_offset = hdr_off;

	// Read data mux; data are captured in the setup cycle and stand through
	// the access, and clear-on-read effects use that captured word
	wire [31:0] cs_view = {rx_cmd_done_count, 20'h00000, rx_cmd_free_count};
	wire [31:0] rd_mux = hit_ev ? event_view :
		hit_mask ? mask :
		hit_cs ? cs_view : 32'h0000_0000;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= rd_mux;
		end
	end

	assign pready = 1'b1;
	// Errors: unmapped address, or a command written to a full queue
	assign pslverr = access && (!mapped || (push == 1'b0 && wr && hit_cmd));

	// Read of events with irq high must drop master enable next cycle
	chk_master_drop: assert property (@(posedge pclk) disable iff (!presetn)
		ev_rd && irq && !(wr && hit_mask) |=> !mask[MASK_MASTER_BIT])
		else $error("master enable not cleared");
	// No interrupt with master enable low
	chk_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
		!$past(irq_master_enable) |-> !irq) else $error("irq without enable");
	// Event sets regardless of mask
	chk_ev_sticky: assert property (@(posedge pclk) disable iff (!presetn)
		tx_event |=> event_bits[EV_TX]) else $error("tx event lost");
	// Bit stays set without read
	chk_ev_hold: assert property (@(posedge pclk) disable iff (!presetn)
		event_bits[EV_TIMER] && !lane_clr[2] |=> event_bits[EV_TIMER])
		else $error("event dropped");
	// An event on the setup edge of a read is not in its data and survives it
	chk_ev_keep: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable && !pwrite && hit_ev && tx_event && !event_bits[EV_TX]
		##1 penable |=> event_bits[EV_TX])
		else $error("event lost on read");
	// Byte lane clear only: returned bits of lane 1 go, lane 0 is untouched
	chk_lane_clear: assert property (@(posedge pclk) disable iff (!presetn)
		lane_clr == 4'h2 && !tx_event |=>
		(event_bits[15:8] & $past(prdata[15:8])) == 8'h00
		&& ($stable(event_bits[7:0]) || $past(pop) || $past(rx_event)))
		else $error("wrong lane cleared");
	// Done count drops by exactly what the top-byte read returned
	chk_done_zero: assert property (@(posedge pclk) disable iff (!presetn)
		lane_clr[3] && !pop |=>
		rx_cmd_done_count == $past(rx_cmd_done_count) - $past(prdata[31:24]))
		else $error("count kept");
	// Finish increments count
	chk_done_inc: assert property (@(posedge pclk) disable iff (!presetn)
		pop && !lane_clr[3] |=> rx_cmd_done_count == $past(rx_cmd_done_count) + 8'h01)
		else $error("count not incremented");
	// Interrupt follows unmasked event
	chk_irq_raise: assert property (@(posedge pclk) disable iff (!presetn)
		next_irq && !ev_rd |=> irq) else $error("irq not raised");
	// Nothing unmasked pending means no interrupt next cycle
	chk_mask_gate: assert property (@(posedge pclk) disable iff (!presetn)
		pending[30:0] == 31'h0 |=> !irq) else $error("irq from masked event");
	// Free count matches fill
	chk_free_count: assert property (@(posedge pclk) disable iff (!presetn)
		push && !pop |=> rx_cmd_free_count == $past(rx_cmd_free_count) - 4'h1)
		else $error("free count wrong");
	// A command written to a full queue is dropped
	chk_full_refuse: assert property (@(posedge pclk) disable iff (!presetn)
		wr && hit_cmd && queue_full && !pop |=> queue_full)
		else $error("command taken while full");
	// Each new header offset lands on an 8-byte boundary
	chk_hdr_align: assert property (@(posedge pclk) disable iff (!presetn)
		rx_event |=> (hdr_off & HDR_ALIGN_MASK) == 16'h0000)
		else $error("header offset misaligned");
endmodule
`default_nettype wire

// ===== tb/rcei_rx_engine.sv
`timescale 1ns/100ps
`default_nettype none
// Receive engine stand-in: finishes the head command after a chosen delay
module rcei_rx_engine (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Request from the bench
	input wire logic go,
	input wire logic [3:0] delay,
	// Toward the block
	output logic rx_cmd_finish,
	output logic busy
);
	logic [3:0] cnt; // Cycles left before the finish pulse
	// One-cycle finish pulse once the count runs out
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 4'h0;
			busy <= 1'b0;
			rx_cmd_finish <= 1'b0;
		end else begin
			rx_cmd_finish <= busy && cnt == 4'h0;
			if (go) begin
				busy <= 1'b1;
				cnt <= delay;
			end else if (busy && cnt == 4'h0) begin
				busy <= 1'b0;
			end else if (busy) begin
				cnt <= cnt - 4'h1;
			end
		end
	end
endmodule
`default_nettype wire

// ===== tb/rx_command_event_interrupt_unit_test.sv
`timescale 1ns/100ps
`default_nettype none
module rx_command_event_interrupt_unit_test;
	import rcei_pkg::*;
	// Bench-driven inputs
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, rx_cur_cmd;
	logic [3:0] pstrb = 4'hf, dly = 4'h0, ev = 4'h0;
	logic [15:0] rx_pkt_len = 16'h0, rx_next_hdr_offset, hdr;
	// Observed outputs
	logic pready, pslverr, rx_cmd_finish, rx_cur_valid, irq, busy, er;
	int err_count = 0, comparisons = 0, cycles = 0;
	rcei_top u_rcei_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb, .prdata, .pready, .pslverr, .rx_event(ev[0]), .tx_event(ev[1]),
		.fifo_event(ev[2]), .timer_event(ev[3]), .rx_cmd_finish, .rx_pkt_len,
		.rx_cur_cmd, .rx_cur_valid, .rx_next_hdr_offset, .irq);
	rcei_rx_engine u_rcei_rx_engine (.pclk, .presetn, .go, .delay(dly), .rx_cmd_finish,
		.busy);
	// Clock and hang guard
	initial forever #50 pclk = ~pclk;
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 6000) begin
			err_count++;
			end_sim();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic end_sim;
		$display("err_count=%0d comparisons=%0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// One APB transfer; holds the request until pready at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// One-cycle event pulse, then let status and irq settle
	task automatic pulse(input logic [3:0] v);
		@(posedge pclk);
		ev <= v;
		@(posedge pclk);
		ev <= 4'h0;
		repeat (2) @(posedge pclk);
	endtask
	// Ask the engine to finish the head command d+1 cycles after it samples go
	task automatic fin(input logic [3:0] d);
		@(posedge pclk);
		go <= 1;
		dly <= d;
		@(posedge pclk);
		go <= 0;
		for (int k = 0; k < 40 && rx_cmd_finish !== 1'b1; k++) @(posedge pclk);
		repeat (2) @(posedge pclk);
	endtask
	task automatic t_sticky;
		pulse(4'hf);
		chk(irq, 0);
		apb(0, ADDR_EVENT_STATUS, 0, 4'hf);
		chk(rd, 32'h0011_0102);
		apb(0, ADDR_EVENT_STATUS, 0, 4'hf);
		chk(rd, 32'h0);
		pulse(4'b0110);
		apb(0, ADDR_EVENT_STATUS, 0, 4'b0010);
		apb(0, ADDR_EVENT_STATUS, 0, 4'hf);
		chk(rd, 32'h0001_0000);
	endtask
	task automatic t_irq;
		apb(1, ADDR_IRQ_MASK, 32'h8000_0100, 4'hf);
		pulse(4'b1000);
		chk(irq, 0);
		pulse(4'b0010);
		chk(irq, 1);
		apb(0, ADDR_EVENT_STATUS, 0, 4'hf);
		chk(rd, 32'h0010_0100);
		repeat (2) @(posedge pclk);
		chk(irq, 0);
		apb(0, ADDR_IRQ_MASK, 0, 4'hf);
		chk(rd, 32'h0000_0100);
		pulse(4'b0010);
		chk(irq, 0);
		apb(1, ADDR_IRQ_MASK, 32'h8000_0100, 4'hf);
		repeat (2) @(posedge pclk);
		chk(irq, 1);
		apb(0, ADDR_EVENT_STATUS, 0, 4'hf);
	endtask
	task automatic t_cmds;
		apb(0, ADDR_CMD_STATUS, 0, 4'hf);
		chk(rd, {DONE_RESET, 20'h0, QUEUE_DEPTH_V});
		for (int i = 1; i <= QUEUE_DEPTH; i++) begin
			apb(1, ADDR_RX_COMMAND, {i[15:0], 16'h0040}, 4'hf);
			chk(er, 0);
		end
		apb(1, ADDR_RX_COMMAND, 32'h0009_0040, 4'hf);
		chk(er, 1);
		chk(rx_cur_valid, 1);
		hdr = rx_next_hdr_offset;
		rx_pkt_len <= 16'h0005;
		pulse(4'b0001);
		chk({16'h0, rx_next_hdr_offset}, {16'h0, hdr + 16'h0010});
		for (int i = 1; i <= 3; i++) begin
			chk(rx_cur_cmd, {i[15:0], 16'h0040});
			fin(i == 2 ? 4'h9 : 4'h0);
		end
		apb(0, ADDR_CMD_STATUS, 0, 4'hf);
		chk(rd, 32'h0300_0003);
		apb(0, ADDR_EVENT_STATUS, 0, 4'hf);
		chk(rd, 32'h0300_0003);
		apb(0, ADDR_CMD_STATUS, 0, 4'hf);
		chk(rd, 32'h0000_0003);
		apb(0, 8'hf0, 0, 4'hf);
		chk(er, 1);
	endtask
	// Reset, then the scenarios in turn
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1;
		apb(0, ADDR_IRQ_MASK, 0, 4'hf);
		chk(rd, MASK_RESET);
		t_sticky();
		t_irq();
		t_cmds();
		end_sim();
	end
endmodule
`default_nettype wire
